// file: vgasr_map.svh
// register offsets, field positions, reset values for the vga register bank
// Behaviour
// - relocatable group decodes at 3Dx when base bit is 1, else 3Bx
// - paired items have two copies; controller select picks the one reached
// - host writes zero to reserved bits; reads of them are undefined
// - misc output written at 3C2, read at 3CC, cleared by reset
// - memory access enable bit 1 at 0 refuses cpu display memory access
// - clock select 00, 01, 11 pick pll pairs; 10 is reserved
// - pll loads on load bit 1 set or bit 5 written 1 then 0
// - page select bit routes cpu accesses to low or high 64K
// - misc bits 7,6 give sync polarities and source vertical size
// - size used only under expansion; simultaneous display overrides polarity
// - feature bit 3 ors vertical display enable into vertical sync
// - status 0 shows sense on bit 4, retrace interrupt on bit 7
// - status 1 bit 0 any retrace, bit 3 vertical retrace, bit 2 one
// - status 1 bits 5,4 show two colour outputs picked by plane enable
// - write-only enable port bit 0 enables device; resets to zero
// - index then data access, or one word write carrying both
// - five-bit sequencer index; data port reaches indexed register
// - sequencer reset bits are storage only with no effect
// - clocking bit 0 selects eight-dot or nine-dot character clocks
// - serializers load every clock, every second, or every fourth
// - clocking bit 3 halves the character clock rate
// - shared screen-off bit blanks only while override control is 0
`ifndef VGASR_MAP_SVH
`define VGASR_MAP_SVH
`define VGASR_MISC_WR 16'h03c2
`define VGASR_MISC_RD 16'h03cc
`define VGASR_STAT0 16'h03c2
`define VGASR_ENABLE 16'h03c3
`define VGASR_SEQ_IDX 16'h03c4
`define VGASR_SEQ_DAT 16'h03c5
`define VGASR_FEAT_RD 16'h03ca
`define VGASR_MONO_A 16'h03ba
`define VGASR_COLOR_A 16'h03da
`define VGASR_SR_RESET 5'h00
`define VGASR_SR_CLKMODE 5'h01
`define VGASR_MISC_MASK 8'hef
`define VGASR_FEAT_MASK 8'h08
`define VGASR_SRRST_MASK 8'h03
`define VGASR_CLKM_MASK 8'h3d
`define VGASR_RESET_VAL 8'h00
`define VGASR_B_IOSEL 0
`define VGASR_B_MEMEN 1
`define VGASR_B_PAGE 5
`define VGASR_B_VSYNC_TYPE_SELECT 3
`define VGASR_B_8DOT 0
`define VGASR_B_SH2 2
`define VGASR_B_HALF 3
`define VGASR_B_SH4 4
`define VGASR_B_SCRN 5
`endif

// file: vgasr_pkg.sv
// types shared by the vga general and sequencer register bank
package vgasr_pkg;
   typedef enum logic [1:0] {
      VGASR_CLK_VGA0 = 2'b00,
      VGASR_CLK_VGA1 = 2'b01,
      VGASR_CLK_RSVD = 2'b10,
      VGASR_CLK_ENH = 2'b11
   } vgasr_clksel_e;
   typedef enum logic [1:0] {
      VGASR_VS_RSVD = 2'b00,
      VGASR_VS_200 = 2'b01,
      VGASR_VS_350 = 2'b10,
      VGASR_VS_480 = 2'b11
   } vgasr_vsize_e;
   typedef logic [7:0] vgasr_byte_t;
endpackage

// file: vgasr_regs.sv
// vga general registers and first sequencer registers, dual controller
`timescale 1ns/1ps
`include "vgasr_map.svh"
module vgasr_regs (
   input wire logic clk_sys, // 100 MHz system clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic [15:0] io_addr, // i/o port address
   input wire logic io_wr, // one-cycle write strobe
   input wire logic io_rd, // one-cycle read strobe
   input wire logic io_word, // write carries 16 bits
   input wire logic [15:0] io_wdata, // write data, high byte for word
   output vgasr_pkg::vgasr_byte_t io_rdata, // read data
   output logic io_rvalid, // read data valid pulse
   input wire logic ctrl_access_sel, // controller access select
   input wire logic pll_load_bit1, // pll load control bit 1
   input wire logic pll_load_bit5, // pll load control bit 5
   output vgasr_pkg::vgasr_clksel_e pll_param_select, // pll pair chosen
   output logic pll_load, // pll parameter transfer pulse
   input wire logic cpu_mem_req, // cpu wants display memory
   output logic cpu_mem_grant, // access permitted
   output logic cpu_mem_refused, // access refused
   output logic high_page_select, // upper 64K page selected
   output logic io_base_color, // group decoded at 3Dx
   input wire logic simultaneous_display, // both displays active
   input wire logic [1:0] simultaneous_sync_polarity, // {v,h} override
   input wire logic vertical_expansion_control, // expansion enabled
   output logic hsync_negative, // horizontal sync negative
   output logic vsync_negative, // vertical sync negative
   output vgasr_pkg::vgasr_vsize_e source_vsize, // source vertical size
   output logic source_vsize_valid, // size applies
   input wire logic vsync_in, // raw vertical sync
   input wire logic vdisplay_enable, // vertical active display
   output logic vsync_out, // vertical sync to monitor
   input wire logic monitor_sense_status, // internal sense level
   input wire logic retrace_interrupt_pending, // vertical retrace irq
   input wire logic hretrace_active, // horizontal retrace
   input wire logic vretrace_active, // vertical retrace
   input wire logic [7:0] attr_color_out, // attribute colour outputs
   input wire logic [1:0] color_plane_enable, // plane enable bits 5,4
   output logic device_enable, // device enabled
   input wire logic screen_off_override_control, // extended control bit
   output logic screen_blank, // screen turned off
   input wire logic [1:0] char_tick, // dot-rate char tick per ctrl
   output logic [1:0] eight_dot_char_select, // 8-dot chars per ctrl
   output logic [1:0] char_clock_tick, // effective char clock per ctrl
   output logic [1:0] serializer_load // serializer load per ctrl
);
   import vgasr_pkg::*;

   vgasr_byte_t misc_r;
   vgasr_byte_t feat_r;
   logic enable_r;
   logic [4:0] seq_index_r;
   vgasr_byte_t srrst_r;
   logic [4:0] clkm_r [2];
   logic screen_off_r;
   logic bit1_d_r;
   logic bit5_d_r;
   logic bit5_armed_r;
   logic pll_load_r;
   vgasr_byte_t rdata_nxt;

   // base-relative address of the relocatable group
   function automatic logic rel_hit(input logic [15:0] a,
                                    input logic color);
      rel_hit = (a == (color ? `VGASR_COLOR_A : `VGASR_MONO_A));
   endfunction

   logic wr_misc;
   logic wr_feat;
   logic wr_enable;
   logic wr_index;
   logic wr_data;
   logic [4:0] tgt_index;
   vgasr_byte_t tgt_data;

   assign wr_misc = io_wr && (io_addr == `VGASR_MISC_WR);
   assign wr_feat = io_wr && rel_hit(io_addr, misc_r[`VGASR_B_IOSEL]);
   assign wr_enable = io_wr && (io_addr == `VGASR_ENABLE);
   assign wr_index = io_wr && (io_addr == `VGASR_SEQ_IDX);
   // word write at index port also writes data
   assign wr_data = io_wr && ((io_addr == `VGASR_SEQ_DAT) ||
                              ((io_addr == `VGASR_SEQ_IDX) && io_word));
   assign tgt_index = (wr_index && io_word) ? io_wdata[4:0] : seq_index_r;
   assign tgt_data = (wr_index && io_word) ? io_wdata[15:8] : io_wdata[7:0];

   // misc written at 3C2, cleared on reset
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         misc_r <= `VGASR_RESET_VAL;
      end else if (wr_misc) begin
         misc_r <= io_wdata[7:0] & `VGASR_MISC_MASK;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         feat_r <= `VGASR_RESET_VAL;
      end else if (wr_feat) begin
         feat_r <= io_wdata[7:0] & `VGASR_FEAT_MASK;
      end
   end

   // enable port bit 0, zero from reset
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         enable_r <= 1'b0;
      end else if (wr_enable) begin
         enable_r <= io_wdata[0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         seq_index_r <= 5'h00;
      end else if (wr_index) begin
         seq_index_r <= io_wdata[4:0];
      end
   end

   // compat reset bits stored only, drive nothing
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         srrst_r <= `VGASR_RESET_VAL;
      end else if (wr_data && tgt_index == `VGASR_SR_RESET) begin
         srrst_r <= tgt_data & `VGASR_SRRST_MASK;
      end
   end

   // paired clocking bits, one copy per controller
   genvar gc;
   generate
      for (gc = 0; gc < 2; gc++) begin : g_clkm
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               clkm_r[gc] <= 5'h00;
            end else if (wr_data && tgt_index == `VGASR_SR_CLKMODE &&
                         ctrl_access_sel == 1'(gc)) begin
               clkm_r[gc] <= tgt_data[4:0] & 5'(`VGASR_CLKM_MASK);
            end
         end
      end
   endgenerate

   // shared screen-off bit written regardless of controller select
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         screen_off_r <= 1'b0;
      end else if (wr_data && tgt_index == `VGASR_SR_CLKMODE) begin
         screen_off_r <= tgt_data[`VGASR_B_SCRN];
      end
   end

   // read multiplexer
   logic st_hit;
   logic [1:0] tst_bits;
   logic [4:0] clkm_sel;
   assign st_hit = rel_hit(io_addr, misc_r[`VGASR_B_IOSEL]);
   assign clkm_sel = clkm_r[ctrl_access_sel];

   // plane enable picks which colour pair feeds back
   always_comb begin
      unique case (color_plane_enable)
         2'b00: tst_bits = {attr_color_out[4], attr_color_out[0]};
         2'b01: tst_bits = {attr_color_out[5], attr_color_out[1]};
         2'b10: tst_bits = {attr_color_out[3], attr_color_out[2]};
         2'b11: tst_bits = {attr_color_out[7], attr_color_out[6]};
      endcase
   end

   always_comb begin
      rdata_nxt = 8'h00;
      if (io_addr == `VGASR_MISC_RD) begin
         rdata_nxt = misc_r;
      end else if (io_addr == `VGASR_STAT0) begin
         rdata_nxt = {retrace_interrupt_pending, 2'b00,
                      monitor_sense_status, 4'h0};
      end else if (io_addr == `VGASR_FEAT_RD) begin
         rdata_nxt = feat_r;
      end else if (st_hit) begin
         // retrace flags with bit 2 forced high
         rdata_nxt = {2'b00, tst_bits, vretrace_active, 1'b1, 1'b0,
                      hretrace_active | vretrace_active};
      end else if (io_addr == `VGASR_SEQ_IDX) begin
         rdata_nxt = {3'b000, seq_index_r};
      end else if (io_addr == `VGASR_SEQ_DAT) begin
         unique case (seq_index_r)
            `VGASR_SR_RESET: rdata_nxt = srrst_r;
            `VGASR_SR_CLKMODE:
               rdata_nxt = {2'b00, screen_off_r, clkm_sel};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         io_rdata <= rdata_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         io_rvalid <= 1'b0;
      end else begin
         io_rvalid <= io_rd;
      end
   end

   // pll load on bit 1 rising or bit 5 going 1 then 0
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         bit1_d_r <= 1'b0;
         bit5_d_r <= 1'b0;
      end else begin
         bit1_d_r <= pll_load_bit1;
         bit5_d_r <= pll_load_bit5;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         bit5_armed_r <= 1'b0;
      end else if (pll_load_bit5) begin
         bit5_armed_r <= 1'b1;
      end else if (bit5_d_r) begin
         bit5_armed_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pll_load_r <= 1'b0;
      end else begin
         pll_load_r <= (pll_load_bit1 && !bit1_d_r) ||
                       (bit5_armed_r && bit5_d_r && !pll_load_bit5);
      end
   end
   assign pll_load = pll_load_r;

   // clock select field passes through; 10 is left reserved
   assign pll_param_select = vgasr_clksel_e'(misc_r[3:2]);

   // memory access gated by enable bit
   assign cpu_mem_grant = cpu_mem_req && misc_r[`VGASR_B_MEMEN];
   assign cpu_mem_refused = cpu_mem_req && !misc_r[`VGASR_B_MEMEN];
   assign high_page_select = misc_r[`VGASR_B_PAGE];
   assign io_base_color = misc_r[`VGASR_B_IOSEL];

   // misc bits 7,6 give polarity; simultaneous overrides
   assign vsync_negative = simultaneous_display ?
                           simultaneous_sync_polarity[1] : misc_r[7];
   assign hsync_negative = simultaneous_display ?
                           simultaneous_sync_polarity[0] : misc_r[6];
   assign source_vsize = vgasr_vsize_e'(misc_r[7:6]);
   // size only applies under expansion, reserved code never valid
   assign source_vsize_valid = vertical_expansion_control &&
                               (misc_r[7:6] != 2'b00);

   assign vsync_out = feat_r[`VGASR_B_VSYNC_TYPE_SELECT] ?
                      (vsync_in | vdisplay_enable) : vsync_in;

   assign device_enable = enable_r;
   // screen-off only while override control is clear
   assign screen_blank = screen_off_r && !screen_off_override_control;

   // character clock and serializer load per controller
   logic [1:0] half_phase_r;
   logic [1:0] ser_cnt_r [2];
   genvar gk;
   generate
      for (gk = 0; gk < 2; gk++) begin : g_cclk
         // eight or nine dot character width
         assign eight_dot_char_select[gk] = clkm_r[gk][`VGASR_B_8DOT];
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               half_phase_r[gk] <= 1'b0;
            end else if (char_tick[gk]) begin
               half_phase_r[gk] <= ~half_phase_r[gk];
            end
         end
         assign char_clock_tick[gk] = char_tick[gk] &&
            (!clkm_r[gk][`VGASR_B_HALF] || half_phase_r[gk]);
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               ser_cnt_r[gk] <= 2'b00;
            end else if (char_clock_tick[gk]) begin
               ser_cnt_r[gk] <= ser_cnt_r[gk] + 2'b01;
            end
         end
         // every fourth wins over every second
         assign serializer_load[gk] = char_clock_tick[gk] &&
            (clkm_r[gk][`VGASR_B_SH4] ? (ser_cnt_r[gk] == 2'b00) :
             clkm_r[gk][`VGASR_B_SH2] ? !ser_cnt_r[gk][0] : 1'b1);
      end
   endgenerate

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   misc_readback_a: assert property (
      io_wr && !io_word && io_addr == `VGASR_MISC_WR ##1
      !io_wr ##1
      io_rd && io_addr == `VGASR_MISC_RD |=>
      io_rdata == ($past(io_wdata[7:0], 3) & `VGASR_MISC_MASK))
      else $error("misc readback mismatch");

   misc_reset_a: assert property (
      $rose(reset_n) |-> misc_r == 8'h00 && !enable_r)
      else $error("misc or enable not cleared");

   mem_refuse_a: assert property (
      cpu_mem_req && !misc_r[1] |-> !cpu_mem_grant && cpu_mem_refused)
      else $error("memory access not refused");

   pll_bit5_a: assert property (
      !pll_load_bit1 && !pll_load_bit5 && $fell(pll_load_bit5)
      |=> pll_load)
      else $error("pll not loaded after bit 5 fell");

   pll_quiet_a: assert property (
      pll_load |-> $past(pll_load_bit1) || $past(pll_load_bit5, 2))
      else $error("pll load without cause");

   feat_base_a: assert property (
      io_wr && io_addr == `VGASR_COLOR_A && !misc_r[0] |=>
      $stable(feat_r))
      else $error("feature write outside base");

   stat1_bits_a: assert property (
      io_rd && st_hit && io_addr != `VGASR_MISC_RD |=>
      io_rdata[2] && io_rdata[3] == $past(vretrace_active))
      else $error("status 1 bits wrong");

   stat0_bits_a: assert property (
      io_rd && io_addr == `VGASR_STAT0 |=>
      io_rdata[7] == $past(retrace_interrupt_pending) &&
      io_rdata[4] == $past(monitor_sense_status))
      else $error("status 0 bits wrong");

   word_write_a: assert property (
      io_wr && io_word && io_addr == `VGASR_SEQ_IDX &&
      io_wdata[4:0] == 5'h00 |=> srrst_r == ($past(io_wdata[15:8]) & 8'h03))
      else $error("word write missed data");

   paired_copy_a: assert property (
      wr_data && tgt_index == 5'h01 && !ctrl_access_sel |=>
      $stable(clkm_r[1]))
      else $error("other controller copy changed");

   blank_gate_a: assert property (
      screen_off_override_control |-> !screen_blank)
      else $error("blank despite override");

   ser_fourth_a: assert property (
      clkm_r[0][4] && serializer_load[0] |-> ser_cnt_r[0] == 2'b00)
      else $error("serializer loaded off fourth tick");

   vsync_or_a: assert property (
      feat_r[3] && vdisplay_enable |-> vsync_out)
      else $error("vsync type select ignored");

endmodule

// file: vgasr_host.sv
// host cpu model issuing byte and word i/o cycles to the register bank
`timescale 1ns/1ps
module vgasr_host (
   input wire logic clk_sys, // system clock
   output logic [15:0] io_addr, // port address
   output logic io_wr, // write strobe
   output logic io_rd, // read strobe
   output logic io_word, // word write flag
   output logic [15:0] io_wdata, // write data
   input wire logic [7:0] io_rdata, // read data
   input wire logic io_rvalid // read data valid
);
   initial begin
      io_addr = 16'h0000;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_word = 1'b0;
      io_wdata = 16'h0000;
   end
   // index then data, or one word cycle
   task automatic wr(input logic [15:0] a, input logic [15:0] d,
                     input logic w);
      @(posedge clk_sys);
      #1;
      io_addr = a;
      io_wdata = d;
      io_word = w;
      io_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      io_wr = 1'b0;
      io_word = 1'b0;
      // released bus shows a changed pattern, not the old value
      io_addr = ~a;
      io_wdata = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d,
                     output logic ok);
      @(posedge clk_sys);
      #1;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge clk_sys);
      #1;
      io_rd = 1'b0;
      io_addr = ~a;
      ok = io_rvalid;
      d = io_rdata;
   endtask
endmodule

// file: tb_top.sv
// self-checking bench for the vga general and sequencer register bank
`timescale 1ns/1ps
module tb_top;
   import vgasr_pkg::*;
   logic clk_sys, reset_n, io_wr, io_rd, io_word, io_rvalid, ctrl_access_sel;
   logic [15:0] io_addr, io_wdata;
   vgasr_byte_t io_rdata;
   logic pll_load_bit1, pll_load_bit5, pll_load, cpu_mem_req, cpu_mem_grant;
   logic cpu_mem_refused, high_page_select, io_base_color;
   logic simultaneous_display, vertical_expansion_control, hsync_negative;
   logic vsync_negative, source_vsize_valid, vsync_in, vdisplay_enable;
   logic vsync_out, monitor_sense_status, retrace_interrupt_pending;
   logic hretrace_active, vretrace_active, device_enable, screen_blank;
   logic screen_off_override_control;
   logic [1:0] simultaneous_sync_polarity, color_plane_enable, char_tick;
   logic [1:0] eight_dot_char_select, char_clock_tick, serializer_load;
   logic [7:0] attr_color_out;
   vgasr_clksel_e pll_param_select;
   vgasr_vsize_e source_vsize;
   int bad_count = 0;
   int total_checks = 0;
   int nck, nld;
   int lo[4] = '{0, 1, 2, 6};
   int hi[4] = '{4, 5, 3, 7};

   vgasr_host vgasr_host_i (.clk_sys(clk_sys), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_word(io_word),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

   vgasr_regs vgasr_regs_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_word(io_word),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .ctrl_access_sel(ctrl_access_sel), .pll_load_bit1(pll_load_bit1),
      .pll_load_bit5(pll_load_bit5), .pll_param_select(pll_param_select),
      .pll_load(pll_load), .cpu_mem_req(cpu_mem_req),
      .cpu_mem_grant(cpu_mem_grant), .cpu_mem_refused(cpu_mem_refused),
      .high_page_select(high_page_select), .io_base_color(io_base_color),
      .simultaneous_display(simultaneous_display),
      .simultaneous_sync_polarity(simultaneous_sync_polarity),
      .vertical_expansion_control(vertical_expansion_control),
      .hsync_negative(hsync_negative), .vsync_negative(vsync_negative),
      .source_vsize(source_vsize), .source_vsize_valid(source_vsize_valid),
      .vsync_in(vsync_in), .vdisplay_enable(vdisplay_enable),
      .vsync_out(vsync_out), .monitor_sense_status(monitor_sense_status),
      .retrace_interrupt_pending(retrace_interrupt_pending),
      .hretrace_active(hretrace_active), .vretrace_active(vretrace_active),
      .attr_color_out(attr_color_out),
      .color_plane_enable(color_plane_enable),
      .device_enable(device_enable),
      .screen_off_override_control(screen_off_override_control),
      .screen_blank(screen_blank), .char_tick(char_tick),
      .eight_dot_char_select(eight_dot_char_select),
      .char_clock_tick(char_clock_tick), .serializer_load(serializer_load));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [15:0] a,
                       input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      vgasr_host_i.rd(a, d, ok);
      chk({n, " valid"}, 8'h01, {7'd0, ok});
      chk(n, e, d);
   endtask
   task automatic seq_wr(input logic [4:0] i, input logic [7:0] d);
      vgasr_host_i.wr(16'h03c4, {11'd0, i}, 1'b0);
      vgasr_host_i.wr(16'h03c5, {8'd0, d}, 1'b0);
   endtask
   task automatic seq_chk(input logic [4:0] i, input logic [7:0] e);
      vgasr_host_i.wr(16'h03c4, {11'd0, i}, 1'b0);
      rchk("sequencer_data_port", 16'h03c5, e);
   endtask
   // counts effective char clocks and loads of controller 0 over n ticks
   task automatic ticks(input int n);
      nck = 0;
      nld = 0;
      repeat (n) begin
         @(posedge clk_sys);
         #1;
         char_tick = 2'b01;
         #1;
         if (char_clock_tick[0] === 1'b1) nck++;
         if (serializer_load[0] === 1'b1) nld++;
         @(posedge clk_sys);
         #1;
         char_tick = 2'b00;
      end
   endtask
   task automatic pll_count(input int n);
      nck = 0;
      repeat (n) begin
         @(posedge clk_sys);
         #1;
         if (pll_load === 1'b1) nck++;
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #50000;
      bad_count++;
      test_done;
   end

   initial begin
      {reset_n, ctrl_access_sel, pll_load_bit1, pll_load_bit5} = '0;
      {cpu_mem_req, simultaneous_display, vertical_expansion_control} = '0;
      {vsync_in, vdisplay_enable, monitor_sense_status} = '0;
      {retrace_interrupt_pending, hretrace_active, vretrace_active} = '0;
      {screen_off_override_control, simultaneous_sync_polarity} = '0;
      {color_plane_enable, char_tick} = '0;
      attr_color_out = 8'h5a;
      repeat (4) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      rchk("misc", 16'h03cc, 8'h00);
      rchk("feature", 16'h03ca, 8'h00);
      chk("enable", 8'h00, {7'd0, device_enable});
      seq_chk(5'h01, 8'h00);
      vgasr_host_i.wr(16'h03c2, 16'h00e3, 1'b0);
      rchk("misc", 16'h03cc, 8'he3);
      chk("base", 8'h01, {7'd0, io_base_color});
      chk("page", 8'h01, {7'd0, high_page_select});
      cpu_mem_req = 1'b1;
      #1;
      chk("grant", 8'h01, {7'd0, cpu_mem_grant});
      vgasr_host_i.wr(16'h03c2, 16'h00e0, 1'b0);
      chk("refuse", 8'h01, {7'd0, cpu_mem_refused});
      chk("grant", 8'h00, {7'd0, cpu_mem_grant});
      chk("base", 8'h00, {7'd0, io_base_color});
      vgasr_host_i.wr(16'h03ba, 16'h0008, 1'b0);
      rchk("feature", 16'h03ca, 8'h08);
      vgasr_host_i.wr(16'h03da, 16'h0000, 1'b0);
      rchk("feature", 16'h03ca, 8'h08);
      vdisplay_enable = 1'b1;
      #1;
      chk("vsync or", 8'h01, {7'd0, vsync_out});
      vgasr_host_i.wr(16'h03ba, 16'h0000, 1'b0);
      chk("vsync plain", 8'h00, {7'd0, vsync_out});
      hretrace_active = 1'b1;
      rchk("status1", 16'h03ba, 8'h25);
      hretrace_active = 1'b0;
      vretrace_active = 1'b1;
      rchk("status1", 16'h03ba, 8'h2d);
      rchk("wrong base", 16'h03da, 8'h00);
      vretrace_active = 1'b0;
      for (int i = 0; i < 4; i++) begin
         color_plane_enable = i[1:0];
         rchk("feedback", 16'h03ba, {2'b00, attr_color_out[hi[i]],
              attr_color_out[lo[i]], 4'h4});
      end
      {monitor_sense_status, retrace_interrupt_pending} = 2'b11;
      rchk("status0", 16'h03c2, 8'h90);
      retrace_interrupt_pending = 1'b0;
      rchk("status0", 16'h03c2, 8'h10);
      vertical_expansion_control = 1'b1;
      for (int i = 0; i < 4; i++) begin
         vgasr_host_i.wr(16'h03c2, {8'd0, i[1:0], 2'b00, i[1:0], 2'b01},
                         1'b0);
         chk("clksel", {6'd0, i[1:0]}, {6'd0, pll_param_select});
         chk("vneg", {7'd0, i[1]}, {7'd0, vsync_negative});
         chk("hneg", {7'd0, i[0]}, {7'd0, hsync_negative});
         chk("vsize", {6'd0, i[1:0]}, {6'd0, source_vsize});
         chk("vsize ok", {7'd0, i != 0}, {7'd0, source_vsize_valid});
      end
      vertical_expansion_control = 1'b0;
      simultaneous_display = 1'b1;
      simultaneous_sync_polarity = 2'b01;
      #1;
      chk("vsize ok", 8'h00, {7'd0, source_vsize_valid});
      chk("sim pol", 8'h01, {6'd0, vsync_negative, hsync_negative});
      simultaneous_display = 1'b0;
      vgasr_host_i.wr(16'h03c3, 16'h0001, 1'b0);
      chk("enable", 8'h01, {7'd0, device_enable});
      vgasr_host_i.wr(16'h03c3, 16'h0000, 1'b0);
      chk("enable", 8'h00, {7'd0, device_enable});
      vgasr_host_i.wr(16'h03c4, 16'h0901, 1'b1);
      rchk("index", 16'h03c4, 8'h01);
      rchk("sequencer_data_port", 16'h03c5, 8'h09);
      chk("8dot", 8'h01, {6'd0, eight_dot_char_select});
      vgasr_host_i.wr(16'h03c4, 16'h0300, 1'b1);
      seq_chk(5'h00, 8'h03);
      seq_chk(5'h1f, 8'h00);
      ctrl_access_sel = 1'b1;
      seq_wr(5'h01, 8'h20);
      chk("8dot", 8'h01, {6'd0, eight_dot_char_select});
      chk("blank", 8'h01, {7'd0, screen_blank});
      ctrl_access_sel = 1'b0;
      seq_chk(5'h01, 8'h29);
      screen_off_override_control = 1'b1;
      #1;
      chk("blank", 8'h00, {7'd0, screen_blank});
      screen_off_override_control = 1'b0;
      seq_wr(5'h01, 8'h00);
      ticks(8);
      chk("loads", 8'd8, nld[7:0]);
      seq_wr(5'h01, 8'h04);
      ticks(8);
      chk("loads 2nd", 8'd4, nld[7:0]);
      seq_wr(5'h01, 8'h10);
      ticks(8);
      chk("loads 4th", 8'd2, nld[7:0]);
      seq_wr(5'h01, 8'h08);
      ticks(8);
      chk("half clk", 8'd4, nck[7:0]);
      pll_load_bit1 = 1'b1;
      pll_count(4);
      chk("pll bit1", 8'd1, nck[7:0]);
      pll_load_bit1 = 1'b0;
      pll_load_bit5 = 1'b1;
      pll_count(3);
      pll_load_bit5 = 1'b0;
      pll_count(4);
      chk("pll bit5", 8'd1, nck[7:0]);
      test_done;
   end
endmodule
